/* shared/cbt_pkg.sv */
package cbt_pkg;
	// register map, byte wide, one register per address
	localparam logic [7:0] ADDR_CFG1 = 8'h00;
	localparam logic [7:0] ADDR_CFG2 = 8'h01;
	localparam logic [7:0] ADDR_CFG3 = 8'h02;
	localparam logic [7:0] ADDR_STAT = 8'h03;
	// field positions
	localparam int CFG1_SJW_LSB    = 6;
	localparam int CFG1_BRP_LSB    = 0;
	localparam int CFG2_PS2SEL_BIT = 7;
	localparam int CFG2_TRIPLE_BIT = 6;
	localparam int CFG2_PH1_LSB    = 3;
	localparam int CFG2_PROP_LSB   = 0;
	localparam int CFG3_PH2_LSB    = 0;
	localparam int STAT_SEG_LSB    = 0;
	localparam int STAT_RXBIT_BIT  = 2;
	localparam int STAT_SYNCED_BIT = 3;
	// quanta counts, all segment arithmetic is five bits wide
	localparam int             SEG_W       = 5;
	localparam logic [SEG_W-1:0] SEG_ZERO  = 5'h00;
	localparam logic [SEG_W-1:0] SEG_ONE   = 5'h01;
	localparam logic [SEG_W-1:0] IPT_TQ    = 5'h02;
	localparam logic [SEG_W-1:0] SEG_MAX   = 5'h08;
	localparam logic [SEG_W-1:0] BIT_MAX_TQ = 5'h19;
	// shortest legal bit at 50 MHz; one quantum is at least two clocks
	localparam int CLK_PERIOD_NS = 20;
	localparam int MIN_BIT_NS    = 1000;
	localparam int MIN_BIT_CLK   = MIN_BIT_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		CBT_SYNC  = 2'b00,
		CBT_PROP  = 2'b01,
		CBT_PH1   = 2'b10,
		CBT_PH2   = 2'b11
	} cbt_seg_e;

	typedef struct packed {
		logic [1:0] jump_width;
		logic [5:0] prescaler_value;
		logic       ps2_select;
		logic       triple_sample_enable;
		logic [2:0] phase1_len;
		logic [2:0] prop_len;
		logic [2:0] phase2_len;
	} cbt_cfg_s;

	localparam cbt_cfg_s CFG_RESET = '0;

	function automatic logic [SEG_W-1:0] cbt_max(input logic [SEG_W-1:0] a,
			input logic [SEG_W-1:0] b);
		return (a > b) ? a : b;
	endfunction : cbt_max

	function automatic logic cbt_maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction : cbt_maj3
endpackage : cbt_pkg

/* rtl/cbt_prescaler.sv */
`timescale 1ns/1ps
module cbt_prescaler
	import cbt_pkg::*;
(
	input  wire logic       clk_i,             // oscillator clock
	input  wire logic       reset_i,           // async reset, high
	input  wire logic       restart_i,         // realign quantum to now
	input  wire logic [5:0] prescaler_value_i, // divisor minus one
	output logic            tq_tick_o,         // last clock of a quantum
	output logic            half_tick_o        // middle of a quantum
);
	logic [6:0] div_reg;
	logic [6:0] last;
	logic [5:0] pv_reg;
	logic       fresh_reg;

	// quantum is two clocks times (value plus one); shortest bit sets top rate
	assign last        = {prescaler_value_i, 1'b1};
	// at or past the end, so a shrunk divisor ends the quantum at once instead of wrapping
	assign tq_tick_o   = (div_reg >= last);
	assign half_tick_o = (div_reg == {1'b0, prescaler_value_i});

	// divider; restart lets a sync edge open a fresh quantum
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_reg <= 7'h00;
		end else if (restart_i || tq_tick_o) begin
			div_reg <= 7'h00;
		end else begin
			div_reg <= div_reg + 7'h01;
		end
	end

	// helper: clocks since last tick, for the period check
	logic [7:0] per_reg;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			per_reg <= 8'h01;
		end else if (restart_i || tq_tick_o) begin
			per_reg <= 8'h01;
		end else begin
			per_reg <= per_reg + 8'h01;
		end
	end

	// a quantum cut by a divisor change is not a full one; skip it in the check
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pv_reg    <= 6'h00;
			fresh_reg <= 1'b0;
		end else begin
			pv_reg <= prescaler_value_i;
			if (pv_reg != prescaler_value_i) begin
				fresh_reg <= 1'b1;
			end else if (tq_tick_o || restart_i) begin
				fresh_reg <= 1'b0;
			end
		end
	end

	chk_tq_period: assert property (@(posedge clk_i) disable iff (reset_i)
		(tq_tick_o && !fresh_reg && pv_reg == prescaler_value_i)
		|-> per_reg == {1'b0, prescaler_value_i, 1'b0} + 8'h02)
		else $error("quantum length differs from prescaler setting");
endmodule : cbt_prescaler

/* rtl/cbt_sampler.sv */
`timescale 1ns/1ps
module cbt_sampler
	import cbt_pkg::*;
(
	input  wire logic clk_i,    // oscillator clock
	input  wire logic reset_i,  // async reset, high
	input  wire logic take_i,   // half-quantum sampling instant
	input  wire logic rx_i,     // synchronised bus level
	input  wire logic triple_i, // majority of three selected
	input  wire logic sample_i, // this instant is the sample point
	output logic      bit_o     // decided bit value, combinational
);
	logic [1:0] hist_reg;

	// keep the two earlier half-quantum samples
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hist_reg <= 2'b11;
		end else if (take_i) begin
			hist_reg <= {hist_reg[0], rx_i};
		end
	end

	// majority voting filters a single glitch at the sample point
	assign bit_o = triple_i ? cbt_maj3(rx_i, hist_reg[0], hist_reg[1]) : rx_i;

	chk_majority: assert property (@(posedge clk_i) disable iff (reset_i)
		(sample_i && triple_i && hist_reg == 2'b00) |-> !bit_o)
		else $error("two dominant samples did not win the vote");
endmodule : cbt_sampler

/* rtl/cbt_bit_timing.sv */
// Function
// - each bit is sync, propagation, phase one, phase two segments in quanta.
// - nominal bit time spans 8 to 25 quanta; the fields here allow 5 to 25.
// - quantum equals two clocks times prescaler value plus one.
// - sync segment is one quantum; edges are expected there.
// - propagation segment is prop_len plus one, 1 to 8 quanta.
// - phase segment one spans 1 to 8 quanta.
// - phase segment two is 1 to 8 quanta, at least two.
// - bus is sampled at the end of phase segment one.
// - triple sampling takes majority of three half-quantum spaced samples.
// - nominal phase two leaves two quanta processing time after the sample point.
// - resynchronisation lengthens phase one or shortens phase two.
// - bit rate up to 1 Mb/s is supported.
// - stuffing guarantees an edge at least every six bits.
// - same timing serves receive sampling and transmit bit boundaries.
// - jump_width plus one, 1 to 4 quanta, bounds each adjustment.
// - ps2_select set picks phase2_len, clear picks phase one; either is floored at two quanta.
// - hard sync on falling edge while idle restarts at sync segment.
// - phase1_len is three bits, phase one is value plus one.
`timescale 1ns/1ps
module cbt_bit_timing
	import cbt_pkg::*;
(
	input  wire logic       clk_i,         // oscillator clock, 50 MHz
	input  wire logic       reset_i,       // async reset, high
	input  wire logic [7:0] addr_i,        // register address
	input  wire logic [7:0] wdata_i,       // register write data
	input  wire logic       we_i,          // write strobe
	input  wire logic       re_i,          // read strobe
	output logic      [7:0] rdata_o,       // read data, cycle after re_i
	input  wire logic       rx_i,          // bus receive pin, async
	input  wire logic       bus_idle_i,    // protocol says bus idle
	input  wire logic       tx_dominant_i, // node sends dominant bit
	output logic            sample_o,      // sample point strobe
	output logic            bit_start_o,   // bit boundary strobe
	output logic            rx_bit_o,      // last decided bit value
	output cbt_seg_e        seg_o          // current segment
);
	cbt_cfg_s         cfg_reg;
	cbt_seg_e         seg_next;
	logic [SEG_W-1:0] cnt_reg;
	logic [SEG_W-1:0] bit_tq_reg;
	logic [SEG_W-1:0] ext_reg;
	logic [SEG_W-1:0] cut_reg;
	logic             synced_reg;
	logic             rx_meta_reg;
	logic             rx_sync_reg;
	logic             rx_last_reg;
	logic             tq_tick;
	logic             half_tick;
	logic             bit_val;
	logic [SEG_W-1:0] prop_n;
	logic [SEG_W-1:0] ph1_n;
	logic [SEG_W-1:0] ph2_fix;
	logic [SEG_W-1:0] ph2_nom;
	logic [SEG_W-1:0] ph1_eff;
	logic [SEG_W-1:0] ph2_eff;
	logic [SEG_W-1:0] sjw_n;
	logic [SEG_W-1:0] seg_len;
	logic [SEG_W-1:0] remain;
	logic             last_q;
	logic             usable;
	logic             pos_err;
	logic             neg_err;
	logic             hard;
	logic             restart;
	logic             lengthen;
	logic             shorten;
	logic             bit_end;
	logic             at_sample;
	logic             cfg_dirty_reg;

	// bus pin crosses into the clock domain through two flops
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			rx_last_reg <= 1'b1;
		end else begin
			rx_meta_reg <= rx_i;
			rx_sync_reg <= rx_meta_reg;
			rx_last_reg <= rx_sync_reg;
		end
	end

	cbt_prescaler u_prescaler (
		.clk_i             (clk_i),
		.reset_i           (reset_i),
		.restart_i         (restart),
		.prescaler_value_i (cfg_reg.prescaler_value),
		.tq_tick_o         (tq_tick),
		.half_tick_o       (half_tick)
	);

	cbt_sampler u_sampler (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.take_i   (tq_tick | half_tick),
		.rx_i     (rx_sync_reg),
		.triple_i (cfg_reg.triple_sample_enable),
		.sample_i (at_sample),
		.bit_o    (bit_val)
	);

	// segment lengths in quanta
	assign prop_n  = {2'b00, cfg_reg.prop_len} + SEG_ONE;
	assign ph1_n   = {2'b00, cfg_reg.phase1_len} + SEG_ONE;
	assign ph2_fix = {2'b00, cfg_reg.phase2_len} + SEG_ONE;
	assign sjw_n   = {3'b000, cfg_reg.jump_width} + SEG_ONE;
	// nominal phase two never drops under the processing time
	assign ph2_nom = cfg_reg.ps2_select ? cbt_max(ph2_fix, IPT_TQ)
	                                    : cbt_max(ph1_n, IPT_TQ);
	assign ph1_eff = ph1_n + ext_reg;
	assign ph2_eff = ph2_nom - cut_reg;

	// length of the segment now running
	always_comb begin
		case (seg_o)
			CBT_SYNC: seg_len = SEG_ONE;
			CBT_PROP: seg_len = prop_n;
			CBT_PH1:  seg_len = ph1_eff;
			CBT_PH2:  seg_len = ph2_eff;
			default:  seg_len = SEG_ONE;
		endcase
	end

	// at or past the end, so a segment shrunk mid-run closes instead of wrapping
	assign last_q    = (cnt_reg >= seg_len - SEG_ONE);
	assign remain    = ph2_eff - cnt_reg;
	assign bit_end   = tq_tick && (seg_o == CBT_PH2) && last_q && !restart;
	assign at_sample = tq_tick && (seg_o == CBT_PH1) && last_q && !restart;

	// edge qualification: falling edge, first in this bit, last sample recessive
	assign usable  = rx_last_reg && !rx_sync_reg && !synced_reg && rx_bit_o;
	assign hard    = usable && bus_idle_i;
	// a transmitter of dominant ignores positive phase errors
	assign pos_err = usable && !bus_idle_i && !tx_dominant_i
	                 && (seg_o == CBT_PROP || seg_o == CBT_PH1);
	assign neg_err = usable && !bus_idle_i && (seg_o == CBT_PH2);
	// small errors act like a hard sync, large ones move by the jump width
	assign restart  = hard || (pos_err && bit_tq_reg <= sjw_n)
	                  || (neg_err && remain <= sjw_n);
	assign lengthen = pos_err && bit_tq_reg > sjw_n;
	assign shorten  = neg_err && remain > sjw_n;

	// next segment in fixed order
	always_comb begin
		case (seg_o)
			CBT_SYNC: seg_next = CBT_PROP;
			CBT_PROP: seg_next = CBT_PH1;
			CBT_PH1:  seg_next = CBT_PH2;
			CBT_PH2:  seg_next = CBT_SYNC;
			default:  seg_next = CBT_SYNC;
		endcase
	end

	// segment sequencer and quantum counters
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			seg_o      <= CBT_SYNC;
			cnt_reg    <= SEG_ZERO;
			bit_tq_reg <= SEG_ZERO;
		end else if (restart) begin
			seg_o      <= CBT_SYNC;
			cnt_reg    <= SEG_ZERO;
			bit_tq_reg <= SEG_ZERO;
		end else if (tq_tick) begin
			if (last_q) begin
				seg_o   <= seg_next;
				cnt_reg <= SEG_ZERO;
			end else begin
				cnt_reg <= cnt_reg + SEG_ONE;
			end
			bit_tq_reg <= bit_end ? SEG_ZERO : bit_tq_reg + SEG_ONE;
		end
	end

	// adjustments live for one bit; only one sync per bit
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ext_reg    <= SEG_ZERO;
			cut_reg    <= SEG_ZERO;
			synced_reg <= 1'b0;
		end else if (restart) begin
			ext_reg    <= SEG_ZERO;
			cut_reg    <= SEG_ZERO;
			synced_reg <= 1'b1;
		end else if (bit_end) begin
			ext_reg    <= SEG_ZERO;
			cut_reg    <= SEG_ZERO;
			synced_reg <= 1'b0;
		end else begin
			if (lengthen) begin
				ext_reg <= sjw_n;
			end
			if (shorten) begin
				cut_reg <= sjw_n;
			end
			if (usable) begin
				synced_reg <= 1'b1;
			end
		end
	end

	// strobes shared by receiver and transmitter
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sample_o    <= 1'b0;
			bit_start_o <= 1'b0;
			rx_bit_o    <= 1'b1;
		end else begin
			sample_o    <= at_sample;
			bit_start_o <= restart || bit_end;
			if (at_sample) begin
				rx_bit_o <= bit_val;
			end
		end
	end

	// configuration writes; values steer the sequencer at once
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cfg_reg <= CFG_RESET;
		end else if (we_i) begin
			case (addr_i)
				ADDR_CFG1: begin
					cfg_reg.jump_width      <= wdata_i[CFG1_SJW_LSB +: 2];
					cfg_reg.prescaler_value <= wdata_i[CFG1_BRP_LSB +: 6];
				end
				ADDR_CFG2: begin
					cfg_reg.ps2_select           <= wdata_i[CFG2_PS2SEL_BIT];
					cfg_reg.triple_sample_enable <= wdata_i[CFG2_TRIPLE_BIT];
					cfg_reg.phase1_len           <= wdata_i[CFG2_PH1_LSB +: 3];
					cfg_reg.prop_len             <= wdata_i[CFG2_PROP_LSB +: 3];
				end
				ADDR_CFG3: begin
					cfg_reg.phase2_len <= wdata_i[CFG3_PH2_LSB +: 3];
				end
				default: begin
					cfg_reg <= cfg_reg;
				end
			endcase
		end
	end

	// a bit that saw a config write has mixed lengths; its phase and bit length checks stand down
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cfg_dirty_reg <= 1'b0;
		end else if (we_i) begin
			cfg_dirty_reg <= 1'b1;
		end else if (restart || bit_end) begin
			cfg_dirty_reg <= 1'b0;
		end
	end

	// read data stands one cycle only; unmapped reads give zero
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= 8'h00;
		end else if (re_i) begin
			rdata_o <= 8'h00;
			case (addr_i)
				ADDR_CFG1: begin
					rdata_o[CFG1_SJW_LSB +: 2] <= cfg_reg.jump_width;
					rdata_o[CFG1_BRP_LSB +: 6] <= cfg_reg.prescaler_value;
				end
				ADDR_CFG2: begin
					rdata_o[CFG2_PS2SEL_BIT]    <= cfg_reg.ps2_select;
					rdata_o[CFG2_TRIPLE_BIT]    <= cfg_reg.triple_sample_enable;
					rdata_o[CFG2_PH1_LSB +: 3]  <= cfg_reg.phase1_len;
					rdata_o[CFG2_PROP_LSB +: 3] <= cfg_reg.prop_len;
				end
				ADDR_CFG3: begin
					rdata_o[CFG3_PH2_LSB +: 3] <= cfg_reg.phase2_len;
				end
				ADDR_STAT: begin
					rdata_o[STAT_SEG_LSB +: 2]  <= seg_o;
					rdata_o[STAT_RXBIT_BIT]     <= rx_bit_o;
					rdata_o[STAT_SYNCED_BIT]    <= synced_reg;
				end
				default: begin
					rdata_o <= 8'h00;
				end
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// checks on the sequencer
	chk_sync_one_tq: assert property (@(posedge clk_i) disable iff (reset_i)
		(tq_tick && seg_o == CBT_SYNC && !restart) |=> seg_o == CBT_PROP && cnt_reg == SEG_ZERO)
		else $error("sync segment lasted other than one quantum");

	chk_prop_len: assert property (@(posedge clk_i) disable iff (reset_i)
		(tq_tick && seg_o == CBT_PROP && !restart && cnt_reg == prop_n - SEG_ONE)
		|=> seg_o == CBT_PH1)
		else $error("propagation segment length wrong");

	chk_ph1_range: assert property (@(posedge clk_i) disable iff (reset_i)
		(seg_o == CBT_PH1 && !cfg_dirty_reg)
		|-> cnt_reg < ph1_eff && ph1_n <= SEG_MAX && ph1_n >= SEG_ONE)
		else $error("phase one out of range");

	chk_ph2_floor: assert property (@(posedge clk_i) disable iff (reset_i)
		ph2_nom >= IPT_TQ && ph2_nom <= SEG_MAX
		&& (cfg_reg.ps2_select || ph2_nom >= ph1_n))
		else $error("phase two below processing time or mis-selected");

	chk_sample_point: assert property (@(posedge clk_i) disable iff (reset_i)
		sample_o |-> seg_o == CBT_PH2 && cnt_reg == SEG_ZERO && $past(seg_o) == CBT_PH1)
		else $error("sample strobe not at end of phase one");

	chk_ipt_after: assert property (@(posedge clk_i) disable iff (reset_i)
		(sample_o && !restart) |-> !bit_end)
		else $error("bit ended inside processing time");

	chk_bit_len: assert property (@(posedge clk_i) disable iff (reset_i)
		(bit_end && !synced_reg && !cfg_dirty_reg) |-> bit_tq_reg + SEG_ONE
		== SEG_ONE + prop_n + ph1_n + ph2_nom && bit_tq_reg < BIT_MAX_TQ)
		else $error("unadjusted bit length differs from segment sum");

	chk_sjw_bound: assert property (@(posedge clk_i) disable iff (reset_i)
		ext_reg <= sjw_n && cut_reg <= sjw_n && !(ext_reg != SEG_ZERO && cut_reg != SEG_ZERO))
		else $error("phase adjustment exceeds jump width");

	chk_hard_sync: assert property (@(posedge clk_i) disable iff (reset_i)
		hard |=> seg_o == CBT_SYNC && cnt_reg == SEG_ZERO && bit_start_o && synced_reg)
		else $error("hard sync did not restart the bit");

	chk_strobe_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
		sample_o |=> !sample_o ##1 !sample_o)
		else $error("sample strobe longer than one cycle");

	chk_boundary_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
		bit_start_o |=> !bit_start_o)
		else $error("bit boundary strobe longer than one cycle");

	chk_ph2_order: assert property (@(posedge clk_i) disable iff (reset_i)
		(tq_tick && seg_o == CBT_PH2 && last_q && !restart)
		|=> seg_o == CBT_SYNC && bit_start_o)
		else $error("phase two did not close the bit");

	chk_ph2_count: assert property (@(posedge clk_i) disable iff (reset_i)
		(seg_o == CBT_PH2 && !cfg_dirty_reg) |-> cnt_reg < ph2_eff)
		else $error("phase two ran past its shortened length");
endmodule : cbt_bit_timing

/* verification/cbt_bus_node.sv */
`timescale 1ns/1ps
// far-side node: pulls the bus dominant for a commanded stretch
module cbt_bus_node (
	input  wire logic        clk_i,   // shared oscillator clock
	input  wire logic        go_i,    // one-cycle start command
	input  wire logic [15:0] delay_i, // clocks before the falling edge
	input  wire logic [15:0] len_i,   // clocks held dominant
	output logic             rx_o,    // bus level, 1 recessive
	output logic             busy_o   // pulse in progress
);
	// recessive between pulses, as the bus is pulled there when released
	// pulses stay well under six bit times, as stuffed traffic would
	initial begin
		rx_o = 1'b1;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (go_i === 1'b1) begin
				busy_o <= 1'b1;
				repeat (delay_i) @(posedge clk_i);
				rx_o <= 1'b0;
				repeat (len_i) @(posedge clk_i);
				rx_o <= 1'b1;
				busy_o <= 1'b0;
			end
		end
	end
endmodule : cbt_bus_node

/* verification/cbt_bit_timing_bench.sv */
`timescale 1ns/1ps
module cbt_bit_timing_bench
	import cbt_pkg::*;
;
	logic        clk_i;
	logic        reset_i;
	logic [7:0]  addr_i;
	logic [7:0]  wdata_i;
	logic        we_i;
	logic        re_i;
	logic [7:0]  rdata_o;
	logic        rx_i;
	logic        bus_idle_i;
	logic        tx_dominant_i;
	logic        sample_o;
	logic        bit_start_o;
	logic        rx_bit_o;
	cbt_seg_e    seg_o;
	logic        go;       // far node start command
	logic [15:0] go_delay; // clocks before its edge
	logic [15:0] go_len;   // clocks held dominant
	int          mismatches;
	int          compares;
	int          n;

	cbt_bit_timing i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .rx_i(rx_i),
		.bus_idle_i(bus_idle_i), .tx_dominant_i(tx_dominant_i), .sample_o(sample_o),
		.bit_start_o(bit_start_o), .rx_bit_o(rx_bit_o), .seg_o(seg_o));
	cbt_bus_node i_node (.clk_i(clk_i), .go_i(go), .delay_i(go_delay), .len_i(go_len),
		.rx_o(rx_i), .busy_o());

	// 50 MHz oscillator
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		we_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask : wr

	// read data live only one cycle after the strobe, zero afterwards
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
		@(posedge clk_i);
		re_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1;
		check("rdata", {8'h00, rdata_o & mask}, {8'h00, exp});
		@(posedge clk_i);
		#1;
		check("rdata idle", {8'h00, rdata_o}, 16'h0000);
	endtask : rd

	// bounded wait for a strobe; a lost strobe ends the run
	task automatic wait_for(input bit on_sample, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk_i);
			#1;
			cnt++;
		end while (((on_sample ? sample_o : bit_start_o) !== 1'b1) && cnt < 3000);
		if (cnt >= 3000) begin
			mismatches++;
			$display("[FAIL] strobe wait expected 1 seen 0");
			end_sim();
		end
		check("segment", {14'h0, seg_o}, {14'h0, on_sample ? CBT_PH2 : CBT_SYNC});
	endtask : wait_for

	// settings all keep the bit at five quanta or more
	task automatic measure(input logic [7:0] c1, c2, c3, input int d, p);
		int cnt;
		wr(ADDR_CFG1, c1);
		wr(ADDR_CFG2, c2);
		wr(ADDR_CFG3, c3);
		wait_for(1'b0, cnt);
		wait_for(1'b0, cnt);
		wait_for(1'b1, cnt);
		check("to sample", 16'(cnt), 16'(d));
		wait_for(1'b0, cnt);
		check("phase two", 16'(cnt), 16'(p));
	endtask : measure

	// aligned to the bit start just seen
	task automatic pulse(input logic [15:0] dly, input logic [15:0] len);
		go <= 1'b1;
		go_delay <= dly;
		go_len <= len;
		@(posedge clk_i);
		go <= 1'b0;
	endtask : pulse

	task automatic t_regs();
		wr(ADDR_CFG1, 8'hA5);
		rd(ADDR_CFG1, 8'hA5, 8'hFF);
		wr(ADDR_CFG2, 8'h5A);
		rd(ADDR_CFG2, 8'h5A, 8'hFF);
		wr(ADDR_CFG3, 8'hFF);
		rd(ADDR_CFG3, 8'h07, 8'hFF);
		wr(ADDR_STAT, 8'hFF);
		rd(ADDR_STAT, 8'h00, 8'hF0);
		rd(8'h10, 8'h00, 8'hFF);
		$display("test regs done");
	endtask : t_regs

	// short glitch hits only the sample point sample; vote rejects it
	task automatic t_triple();
		int cnt;
		tx_dominant_i <= 1'b1;
		for (int t = 0; t < 2; t++) begin
			measure(8'h03, t ? 8'h48 : 8'h08, 8'h00, 32, 16);
			wait_for(1'b0, cnt);
			pulse(16'd26, 16'd3);
			wait_for(1'b1, cnt);
			check("glitch timing", 16'(cnt + 1), 16'd32);
			check("voted bit", {15'h0, rx_bit_o}, {15'h0, t[0]});
		end
		tx_dominant_i <= 1'b0;
		$display("test triple done");
	endtask : t_triple

	// edge late in propagation: phase one grows by the jump, or restart
	task automatic t_resync(input logic [1:0] code, input logic idle);
		int cnt;
		bus_idle_i <= idle;
		measure({code, 6'h03}, 8'h1B, 8'h00, 72, 32);
		wait_for(1'b0, cnt);
		pulse(16'd25, idle ? 16'd200 : 16'd8);
		if (code == 2'd3 || idle) begin
			wait_for(1'b0, cnt);
			check("early restart", {15'h0, cnt + 1 < 72}, 16'h0001);
			wait_for(1'b1, cnt);
			check("restart sample", 16'(cnt), 16'd72);
			check("dominant bit", {15'h0, rx_bit_o}, {15'h0, !idle});
		end else begin
			wait_for(1'b1, cnt);
			check("lengthened", 16'(cnt + 1), 16'(72 + 8 * (code + 1)));
		end
		bus_idle_i <= 1'b0;
		$display("test resync done");
	endtask : t_resync

	initial begin
		mismatches = 0;
		compares = 0;
		reset_i = 1'b1;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		we_i = 1'b0;
		re_i = 1'b0;
		bus_idle_i = 1'b0;
		tx_dominant_i = 1'b0;
		go = 1'b0;
		go_delay = 16'h0000;
		go_len = 16'h0000;
		repeat (2) @(posedge clk_i);
		check("reset outputs", {8'h00, rdata_o}, 16'h0000);
		check("reset strobes", {11'h0, sample_o, bit_start_o, rx_bit_o, seg_o}, 16'h0004);
		reset_i <= 1'b0;
		rd(ADDR_CFG1, 8'h00, 8'hFF);
		rd(ADDR_CFG2, 8'h00, 8'hFF);
		rd(ADDR_CFG3, 8'h00, 8'hFF);
		rd(ADDR_STAT, 8'h00, 8'hF0);
		t_regs();
		// quanta table: default, 25 quanta, ph2 from ph1, ph2 floor, max divisor, 1 us bit
		measure(8'h00, 8'h00, 8'h00, 6, 4);
		measure(8'h03, 8'hBF, 8'h07, 136, 64);
		measure(8'h01, 8'h22, 8'h00, 36, 20);
		measure(8'h00, 8'h91, 8'h00, 12, 4);
		measure(8'h3F, 8'h80, 8'h05, 384, 768);
		measure(8'h00, 8'hBF, 8'h07, 34, 16);
		$display("test timing done");
		t_triple();
		t_resync(2'd0, 1'b0);
		t_resync(2'd1, 1'b0);
		t_resync(2'd3, 1'b0);
		t_resync(2'd0, 1'b1);
		end_sim();
	end
endmodule : cbt_bit_timing_bench
